/* verilog/i2cs_slave.sv */
// two-wire slave engine: address recognition, transmit and receive
//
// Contract
// - own address register holds ten bits
// - seven-bit mode matches low seven address bits
// - ten-bit header is 11110 plus A9 A8
// - second ten-bit byte matches low eight bits
// - general call, reserved, header codes never match
// - enabled slave idles until a Start
// - shift eight bits; bits 7:1 address, 0 direction
// - sample bus bits on SCL rising edge
// - match: acknowledge, event on ninth falling edge
// - address match leaves receive buffer untouched
// - read match: transmit, acknowledge, stretch SCL
// - clock release with transmit buffer full frees SCL, eight bits out
// - transmit SDA changes on SCL falling edge
// - event after each sent byte, any ack
// - free buffer, no overflow: load and acknowledge
// - buffer full: no ack, no load, event
// - overflow without full: load, but not acknowledge
// - ten-bit header miss or read: clear, idle
// - ten-bit second match: event, set match flag
`timescale 1ns/1ns
`include "i2cs_cfg.svh"
module i2cs_slave
    import i2cs_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // bus pins, open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe_o,
    output logic sda_o,
    output logic sda_oe_o,
    // control
    input wire logic module_enable_bit_i,
    input wire logic ten_bit_address_select_i,
    input wire logic [9:0] own_slave_address_i,
    input wire logic clock_release_bit_i,
    input wire logic [7:0] transmit_buffer_i,
    input wire logic transmit_buffer_wr_i,
    input wire logic receive_buffer_rd_i,
    input wire logic overflow_clear_i,
    // status
    output logic [7:0] receive_buffer_o,
    output logic receive_buffer_full_o,
    output logic receive_overflow_flag_o,
    output logic slave_event_flag_o,
    output logic ten_bit_match_flag_o,
    output logic read_write_o,
    output logic transmit_buffer_full_o
);
    // =========================================================
    // bus sampling
    i2cs_edge_if bus_ev ();

    i2cs_bus_sampler u_sampler (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .bus_ev(bus_ev)
    );

    // =========================================================
    // state
    i2cs_state_t state_reg;
    i2cs_state_t state_next;
    i2cs_state_t after_reg;
    i2cs_state_t after_next;
    logic [3:0] bit_cnt_reg;
    logic [3:0] bit_cnt_next;
    logic [7:0] receive_shift_reg;
    logic [7:0] receive_shift_next;
    logic [7:0] tx_shift_reg;
    logic [7:0] tx_shift_next;
    logic sda_oe_next;
    logic scl_oe_next;
    logic rw_next;
    logic ev_pulse;
    logic rx_load;
    logic ov_set;
    logic ten_set;
    logic ten_clr;
    logic tx_take;
    logic addr7_hit;
    logic hdr_hit;
    logic lo_hit;

    // address codes that are never a slave's own 7-bit address
    function automatic logic addr_reserved(input logic [6:0] a);
        addr_reserved = (a <= `I2CS_GEN_CALL_MAX) || (a >= `I2CS_TEN_SPACE_MIN);
    endfunction

    // =========================================================
    // address compare
    always_comb
    begin
        addr7_hit = !ten_bit_address_select_i
            && (receive_shift_reg[7:1] == own_slave_address_i[6:0])
            && !addr_reserved(own_slave_address_i[6:0]);
        hdr_hit = ten_bit_address_select_i
            && (receive_shift_reg[7:3] == `I2CS_TEN_HDR)
            && (receive_shift_reg[2:1] == own_slave_address_i[9:8])
            && !receive_shift_reg[0];
        lo_hit = (receive_shift_reg == own_slave_address_i[7:0]);
    end

    // =========================================================
    // sequencer
    always_comb
    begin
        state_next = state_reg;
        after_next = after_reg;
        bit_cnt_next = bit_cnt_reg;
        receive_shift_next = receive_shift_reg;
        tx_shift_next = tx_shift_reg;
        sda_oe_next = sda_oe_o;
        scl_oe_next = scl_oe_o;
        rw_next = read_write_o;
        ev_pulse = 1'b0;
        rx_load = 1'b0;
        ov_set = 1'b0;
        ten_set = 1'b0;
        ten_clr = 1'b0;
        tx_take = 1'b0;
        if (!module_enable_bit_i || bus_ev.stop_det)
        begin
            state_next = I2CS_IDLE;
            sda_oe_next = 1'b0;
            scl_oe_next = 1'b0;
        end
        else if (bus_ev.start_det)
        begin
            state_next = I2CS_ADDR;
            bit_cnt_next = `I2CS_RST_CNT;
            sda_oe_next = 1'b0;
            scl_oe_next = 1'b0;
        end
        else
        begin
            unique case (state_reg)
                I2CS_IDLE:
                begin
                    sda_oe_next = 1'b0;
                    scl_oe_next = 1'b0;
                end
                I2CS_ADDR, I2CS_ADDR2, I2CS_RX_BITS:
                begin
                    if (bus_ev.scl_rise && bit_cnt_reg != `I2CS_LAST_BIT)
                    begin
                        receive_shift_next = {receive_shift_reg[6:0], bus_ev.sda_level};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end
                    else if (bus_ev.scl_fall && bit_cnt_reg == `I2CS_LAST_BIT)
                    begin
                        state_next = I2CS_ACK_OUT;
                        if (state_reg == I2CS_ADDR && addr7_hit)
                        begin
                            sda_oe_next = 1'b1;
                            rw_next = receive_shift_reg[0];
                            after_next = receive_shift_reg[0] ? I2CS_TX_HOLD
                                : I2CS_RX_BITS;
                        end
                        else if (state_reg == I2CS_ADDR && hdr_hit)
                        begin
                            sda_oe_next = 1'b1;
                            rw_next = 1'b0;
                            ten_clr = 1'b1;
                            after_next = I2CS_ADDR2;
                        end
                        else if (state_reg == I2CS_ADDR2 && lo_hit)
                        begin
                            sda_oe_next = 1'b1;
                            ten_set = 1'b1;
                            after_next = I2CS_RX_BITS;
                        end
                        else if (state_reg == I2CS_RX_BITS)
                        begin
                            rx_load = !receive_buffer_full_o;
                            ov_set = receive_buffer_full_o;
                            sda_oe_next = !receive_buffer_full_o
                                && !receive_overflow_flag_o;
                            after_next = I2CS_RX_BITS;
                        end
                        else
                        begin
                            state_next = I2CS_IDLE;
                            ten_clr = ten_bit_address_select_i;
                        end
                    end
                end
                I2CS_ACK_OUT:
                begin
                    if (bus_ev.scl_fall)
                    begin
                        ev_pulse = 1'b1;
                        sda_oe_next = 1'b0;
                        bit_cnt_next = `I2CS_RST_CNT;
                        state_next = after_reg;
                        scl_oe_next = (after_reg == I2CS_TX_HOLD);
                    end
                end
                I2CS_TX_HOLD:
                begin
                    scl_oe_next = 1'b1;
                    if (clock_release_bit_i && transmit_buffer_full_o)
                    begin
                        tx_take = 1'b1;
                        tx_shift_next = transmit_buffer_i;
                        sda_oe_next = !transmit_buffer_i[7];
                        scl_oe_next = 1'b0;
                        bit_cnt_next = `I2CS_RST_CNT;
                        state_next = I2CS_TX_BITS;
                    end
                end
                I2CS_TX_BITS:
                begin
                    if (bus_ev.scl_fall)
                    begin
                        if (bit_cnt_reg == `I2CS_LAST_TX_FALL)
                        begin
                            sda_oe_next = 1'b0;
                            state_next = I2CS_TX_ACK;
                        end
                        else
                        begin
                            tx_shift_next = {tx_shift_reg[6:0], 1'b0};
                            sda_oe_next = !tx_shift_reg[6];
                            bit_cnt_next = bit_cnt_reg + 4'h1;
                        end
                    end
                end
                I2CS_TX_ACK:
                begin
                    if (bus_ev.scl_rise)
                    begin
                        receive_shift_next[0] = bus_ev.sda_level;
                    end
                    else if (bus_ev.scl_fall)
                    begin
                        ev_pulse = 1'b1;
                        scl_oe_next = !receive_shift_reg[0];
                        state_next = receive_shift_reg[0] ? I2CS_IDLE : I2CS_TX_HOLD;
                    end
                end
            endcase
        end
    end

    // =========================================================
    // sequencer registers
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            state_reg <= I2CS_IDLE;
            after_reg <= I2CS_IDLE;
            bit_cnt_reg <= `I2CS_RST_CNT;
            receive_shift_reg <= `I2CS_RST_BYTE;
            tx_shift_reg <= `I2CS_RST_TX_BYTE;
            read_write_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            state_reg <= state_next;
            after_reg <= after_next;
            bit_cnt_reg <= bit_cnt_next;
            receive_shift_reg <= receive_shift_next;
            tx_shift_reg <= tx_shift_next;
            read_write_o <= rw_next;
        end
    end

    // =========================================================
    // pin drive: lines are only ever pulled low
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_o <= 1'b0;
            scl_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            sda_oe_o <= sda_oe_next;
            scl_oe_o <= scl_oe_next;
            sda_o <= 1'b0;
            scl_o <= 1'b0;
        end
    end

    // =========================================================
    // receive buffer and flags; a hardware set wins over a clear
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            receive_buffer_o <= `I2CS_RST_BYTE;
            receive_buffer_full_o <= 1'b0;
            receive_overflow_flag_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (rx_load)
            begin
                receive_buffer_o <= receive_shift_reg;
            end
            if (rx_load)
            begin
                receive_buffer_full_o <= 1'b1;
            end
            else if (receive_buffer_rd_i)
            begin
                receive_buffer_full_o <= 1'b0;
            end
            if (ov_set)
            begin
                receive_overflow_flag_o <= 1'b1;
            end
            else if (overflow_clear_i)
            begin
                receive_overflow_flag_o <= 1'b0;
            end
        end
    end

    // =========================================================
    // transmit buffer holding flag, event pulse, ten-bit match flag
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            transmit_buffer_full_o <= 1'b0;
            slave_event_flag_o <= 1'b0;
            ten_bit_match_flag_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (transmit_buffer_wr_i)
            begin
                transmit_buffer_full_o <= 1'b1;
            end
            else if (tx_take)
            begin
                transmit_buffer_full_o <= 1'b0;
            end
            slave_event_flag_o <= ev_pulse;
            if (ten_set)
            begin
                ten_bit_match_flag_o <= 1'b1;
            end
            else if (ten_clr)
            begin
                ten_bit_match_flag_o <= 1'b0;
            end
        end
    end
endmodule // i2cs_slave

/* include/i2cs_cfg.svh */
// constants of the two-wire slave engine
`ifndef I2CS_CFG_SVH
`define I2CS_CFG_SVH

// address space
`define I2CS_TEN_HDR 5'h1E
`define I2CS_GEN_CALL_MAX 7'h03
`define I2CS_TEN_SPACE_MIN 7'h78
// byte framing
`define I2CS_LAST_BIT 4'h8
`define I2CS_LAST_TX_FALL 4'h7
// reset values
`define I2CS_RST_BYTE 8'h00
`define I2CS_RST_TX_BYTE 8'hFF
`define I2CS_RST_CNT 4'h0

`endif

/* include/i2cs_pkg.sv */
// types of the two-wire slave engine
package i2cs_pkg;

    typedef enum logic [2:0] {
        I2CS_IDLE,
        I2CS_ADDR,
        I2CS_ADDR2,
        I2CS_ACK_OUT,
        I2CS_TX_HOLD,
        I2CS_TX_BITS,
        I2CS_TX_ACK,
        I2CS_RX_BITS
    } i2cs_state_t;

endpackage

/* include/i2cs_edge_if.sv */
// synchronised bus levels and bus events from sampler to engine
`timescale 1ns/1ns
interface i2cs_edge_if;
    logic scl_level;
    logic sda_level;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    modport src (
        output scl_level,
        output sda_level,
        output scl_rise,
        output scl_fall,
        output start_det,
        output stop_det
    );

    modport dst (
        input scl_level,
        input sda_level,
        input scl_rise,
        input scl_fall,
        input start_det,
        input stop_det
    );
endinterface

/* verilog/i2cs_bus_sampler.sv */
// pin synchroniser and SCL / SDA event detector
`timescale 1ns/1ns
module i2cs_bus_sampler (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    // events
    i2cs_edge_if.src bus_ev
);
    // =========================================================
    // three-flop synchronisers, then one history stage
    logic [1:0] scl_meta_reg;
    logic [1:0] sda_meta_reg;
    logic scl_sync_reg;
    logic sda_sync_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            scl_meta_reg <= 2'h3;
            sda_meta_reg <= 2'h3;
            scl_sync_reg <= 1'h1;
            sda_sync_reg <= 1'h1;
            scl_prev_reg <= 1'h1;
            sda_prev_reg <= 1'h1;
        end
        else if (clk_en_i)
        begin
            scl_meta_reg <= {scl_meta_reg[0], scl_i};
            sda_meta_reg <= {sda_meta_reg[0], sda_i};
            scl_sync_reg <= scl_meta_reg[1];
            sda_sync_reg <= sda_meta_reg[1];
            scl_prev_reg <= scl_sync_reg;
            sda_prev_reg <= sda_sync_reg;
        end
    end

    // =========================================================
    // events, valid for one enabled cycle
    assign bus_ev.scl_level = scl_sync_reg;
    assign bus_ev.sda_level = sda_sync_reg;
    assign bus_ev.scl_rise = clk_en_i & scl_sync_reg & ~scl_prev_reg;
    assign bus_ev.scl_fall = clk_en_i & ~scl_sync_reg & scl_prev_reg;
    assign bus_ev.start_det = clk_en_i & scl_sync_reg & scl_prev_reg
        & ~sda_sync_reg & sda_prev_reg;
    assign bus_ev.stop_det = clk_en_i & scl_sync_reg & scl_prev_reg
        & sda_sync_reg & ~sda_prev_reg;
endmodule // i2cs_bus_sampler

/* tb/i2cs_slave_chk.sv */
// assertion checker watching the slave engine ports
`timescale 1ns/1ns
module i2cs_slave_chk (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // bus
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    // control
    input wire logic module_enable_bit_i,
    input wire logic ten_bit_address_select_i,
    input wire logic [9:0] own_slave_address_i,
    input wire logic clock_release_bit_i,
    input wire logic [7:0] transmit_buffer_i,
    input wire logic transmit_buffer_wr_i,
    input wire logic receive_buffer_rd_i,
    input wire logic overflow_clear_i,
    // status
    input wire logic [7:0] receive_buffer_o,
    input wire logic receive_buffer_full_o,
    input wire logic receive_overflow_flag_o,
    input wire logic slave_event_flag_o,
    input wire logic ten_bit_match_flag_o,
    input wire logic read_write_o,
    input wire logic transmit_buffer_full_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // ==========
    // properties
    AST_DRIVE_LOW: assert property ((scl_oe_o || sda_oe_o) |-> !scl_o && !sda_o)
        else $error("pin drive value not low");
    AST_EVT_PULSE: assert property (slave_event_flag_o |=> !slave_event_flag_o)
        else $error("event longer than one cycle");
    AST_EVT_SCL_LOW: assert property (slave_event_flag_o |-> !scl_i)
        else $error("event outside SCL low");
    AST_SDA_ON_LOW: assert property ($changed(sda_oe_o) && module_enable_bit_i |-> !$past(scl_i))
        else $error("SDA changed while SCL high");
    AST_STRETCH: assert property (scl_oe_o && !clock_release_bit_i && module_enable_bit_i
        |=> scl_oe_o)
        else $error("SCL stretch dropped early");
    AST_RELEASE: assert property (scl_oe_o && transmit_buffer_full_o && clock_release_bit_i
        && clk_en_i |=> !scl_oe_o)
        else $error("SCL not released");
    AST_FULL_HOLD: assert property (receive_buffer_full_o |=> $stable(receive_buffer_o))
        else $error("buffer loaded while full");
    AST_LOAD_FULL: assert property (!$stable(receive_buffer_o) |-> receive_buffer_full_o)
        else $error("load without full flag");
    AST_RD_CLR: assert property (receive_buffer_rd_i && scl_i |=> !receive_buffer_full_o)
        else $error("read did not clear full");
    AST_OVF_KEEP: assert property (receive_overflow_flag_o && !overflow_clear_i
        |=> receive_overflow_flag_o)
        else $error("overflow not sticky");
    AST_OFF_IDLE: assert property (!module_enable_bit_i [*2] |-> !sda_oe_o && !scl_oe_o)
        else $error("disabled slave drives bus");
    cover property (receive_buffer_full_o && receive_overflow_flag_o);
    cover property ($rose(ten_bit_match_flag_o));
    cover property ($rose(scl_oe_o));
endmodule // i2cs_slave_chk

/* tb/i2cs_mst.sv */
// behavioural two-wire bus master driving open-drain pull-downs
`timescale 1ns/1ns
module i2cs_mst (
    // clock
    input wire logic ref_clk_i,
    // bus levels
    input wire logic scl_i,
    input wire logic sda_i,
    // pull-downs
    output logic scl_low_o,
    output logic sda_low_o
);
    // ==========
    // bus cycles, 32 clocks a bit
    initial
    begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    // release SCL, then wait out any stretch, bounded
    task automatic rise();
        int i;
        scl_low_o = 1'b0;
        i = 0;
        wt(1);
        while (scl_i !== 1'b1 && i < 5000)
        begin
            wt(1);
            i++;
        end
        wt(15);
    endtask
    task automatic start();
        sda_low_o = 1'b0;
        wt(8);
        sda_low_o = 1'b1;
        wt(16);
        scl_low_o = 1'b1;
        wt(8);
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        wt(8);
        rise();
        sda_low_o = 1'b0;
        wt(16);
    endtask
    task automatic bitx(input logic b, output logic r);
        sda_low_o = !b;
        wt(8);
        rise();
        r = sda_i;
        scl_low_o = 1'b1;
        wt(8);
    endtask
    // eight bits out and in, then the ninth bit: mack pulls it low
    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(d[i], q[i]);
        bitx(!mack, r);
        ack = !r;
    endtask
endmodule // i2cs_mst

/* tb/i2cs_slave_tb.sv */
// self-checking bench of the two-wire slave engine
`timescale 1ns/1ns
module i2cs_slave_tb;
    import i2cs_pkg::*;
    logic ref_clk_i, reset_i, scl_w, sda_w, m_scl, m_sda, scl_o, scl_oe_o, sda_o, sda_oe_o;
    logic en, ten, rel, wr, rd, oclr, receive_buffer_full, rovf, sev, tfl, rw, tenf, a, e, ce;
    logic [9:0] own;
    logic [7:0] txb, rbuf, q, d;
    logic [6:0] o7;
    logic [6:0] rsv [4] = '{7'h00, 7'h00, 7'h78, 7'h7C};
    int miscompares, n_compared, ev_exp, ev_seen, cyc, m_full, m_ovf, m_buf;
    assign scl_w = !(m_scl || (scl_oe_o && !scl_o));
    assign sda_w = !(m_sda || (sda_oe_o && !sda_o));
    i2cs_slave i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(ce),
        .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .module_enable_bit_i(en), .ten_bit_address_select_i(ten),
        .own_slave_address_i(own), .clock_release_bit_i(rel), .transmit_buffer_i(txb),
        .transmit_buffer_wr_i(wr), .receive_buffer_rd_i(rd), .overflow_clear_i(oclr),
        .receive_buffer_o(rbuf), .receive_buffer_full_o(receive_buffer_full), .receive_overflow_flag_o(rovf),
        .slave_event_flag_o(sev), .ten_bit_match_flag_o(tenf), .read_write_o(rw),
        .transmit_buffer_full_o(tfl));
    i2cs_mst i_mst (.ref_clk_i(ref_clk_i), .scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl),
        .sda_low_o(m_sda));
    // ==========
    // helpers
    initial
    begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = !ref_clk_i;
    end
    always @(negedge ref_clk_i)
    begin
        if (sev === 1'b1)
            ev_seen++;
        cyc++;
        if (cyc == 40000)
        begin
            miscompares++;
            summarize();
        end
    end
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
        n_compared++;
        if (g !== ex)
        begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", nm, ex, g);
        end
    endtask
    // reference model of one received data byte
    task automatic mdl(input logic [7:0] b, output logic ak);
        ak = 1'b0;
        if (m_full != 0)
            m_ovf = 1;
        else
        begin
            m_buf = b;
            m_full = 1;
            ak = (m_ovf == 0);
        end
    endtask
    task automatic cmpm();
        chk("rx buffer", 8'(m_buf), rbuf);
        chk("full", 8'(m_full), {7'h00, receive_buffer_full});
        chk("overflow", 8'(m_ovf), {7'h00, rovf});
    endtask
    task automatic send(input logic [7:0] b, input logic ex);
        i_mst.xfer(b, 1'b0, q, a);
        chk("ack", {7'h00, ex}, {7'h00, a});
    endtask
    task automatic pulse_sw(input int which);
        @(negedge ref_clk_i);
        if (which == 0) rd = 1'b1; else oclr = 1'b1;
        @(negedge ref_clk_i);
        rd = 1'b0;
        oclr = 1'b0;
    endtask
    // ==========
    // tests
    initial
    begin
        {reset_i, en, ten, rel, wr, rd, oclr} = 7'h40;
        ce = 1'b1;
        own = 10'h000;
        txb = 8'h00;
        void'($urandom(57));
        repeat (8) @(negedge ref_clk_i);
        reset_i = 1'b0;
        repeat (6) @(negedge ref_clk_i);
        o7 = 7'($urandom_range(8'h77, 8'h08));
        own = {3'h0, o7};
        en = 1'b1;
        i_mst.start();
        send({o7, 1'b0}, 1'b1);
        ev_exp++;
        cmpm();
        for (int k = 0; k < 3; k++)
        begin
            if (k == 2) pulse_sw(0);
            if (k == 2) m_full = 0;
            d = 8'($urandom);
            mdl(d, e);
            send(d, e);
            ev_exp++;
            cmpm();
        end
        i_mst.stop();
        pulse_sw(1);
        pulse_sw(0);
        m_ovf = 0;
        m_full = 0;
        cmpm();
        chk("events", 8'(ev_exp), 8'(ev_seen));
        $display("test write done");
        for (int c = 0; c < 4; c++)
        begin
            own = {3'h0, c == 0 ? o7 : rsv[c]};
            i_mst.start();
            send({c == 0 ? o7 ^ 7'h01 : rsv[c], 1'b0}, 1'b0);
            i_mst.stop();
        end
        own = {3'h0, o7};
        chk("events", 8'(ev_exp), 8'(ev_seen));
        $display("test refuse done");
        i_mst.start();
        send({o7, 1'b1}, 1'b1);
        ev_exp++;
        chk("direction", 8'h01, {7'h00, rw});
        for (int k = 0; k < 2; k++)
        begin
            d = 8'($urandom);
            fork
                i_mst.xfer(8'hFF, k == 0, q, a);
                begin
                    repeat (60) @(negedge ref_clk_i);
                    chk("stretch", 8'h01, {7'h00, scl_oe_o});
                    txb = d;
                    ce = 1'b0;
                    wr = 1'b1;
                    rel = 1'b0;
                    @(negedge ref_clk_i);
                    ce = 1'b1;
                    chk("frozen tx full", 8'h00, {7'h00, tfl});
                    @(negedge ref_clk_i);
                    wr = 1'b0;
                    chk("tx full", 8'h01, {7'h00, tfl});
                    rel = 1'b1;
                end
            join
            chk("tx byte", d, q);
            chk("tx full", 8'h00, {7'h00, tfl});
            ev_exp++;
        end
        i_mst.stop();
        rel = 1'b0;
        chk("events", 8'(ev_exp), 8'(ev_seen));
        $display("test read done");
        ten = 1'b1;
        own = 10'($urandom);
        i_mst.start();
        send({5'h1E, own[9:8], 1'b0}, 1'b1);
        ev_exp++;
        chk("ten flag", 8'h00, {7'h00, tenf});
        send(own[7:0], 1'b1);
        ev_exp++;
        chk("ten flag", 8'h01, {7'h00, tenf});
        d = 8'($urandom);
        mdl(d, e);
        send(d, e);
        ev_exp++;
        cmpm();
        i_mst.stop();
        for (int c = 0; c < 3; c++)
        begin
            i_mst.start();
            send(c == 1 ? {5'h1E, ~own[9:8], 1'b0} : {5'h1E, own[9:8], c == 0}, c == 2);
            if (c == 2) ev_exp++;
            if (c == 2) send(own[7:0] ^ 8'h01, 1'b0);
            i_mst.stop();
            chk("ten flag", 8'h00, {7'h00, tenf});
        end
        chk("ten flag", 8'h00, {7'h00, tenf});
        chk("events", 8'(ev_exp), 8'(ev_seen));
        $display("test ten-bit done");
        summarize();
    end
endmodule // i2cs_slave_tb
bind i2cs_slave i2cs_slave_chk i_chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .clk_en_i(clk_en_i), .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .module_enable_bit_i(module_enable_bit_i),
    .ten_bit_address_select_i(ten_bit_address_select_i),
    .own_slave_address_i(own_slave_address_i), .clock_release_bit_i(clock_release_bit_i),
    .transmit_buffer_i(transmit_buffer_i), .transmit_buffer_wr_i(transmit_buffer_wr_i),
    .receive_buffer_rd_i(receive_buffer_rd_i), .overflow_clear_i(overflow_clear_i),
    .receive_buffer_o(receive_buffer_o), .receive_buffer_full_o(receive_buffer_full_o),
    .receive_overflow_flag_o(receive_overflow_flag_o),
    .slave_event_flag_o(slave_event_flag_o), .ten_bit_match_flag_o(ten_bit_match_flag_o),
    .read_write_o(read_write_o), .transmit_buffer_full_o(transmit_buffer_full_o));
